// File: rtl/motion_start_input_dispatcher.sv
/*
 * Motion start dispatcher: decodes start, sequential, direct, home
 * and run inputs into requests for the profile generator, and holds
 * home settings, direct maps and status behind an APB slave.
 * Assumes pins are asynchronous and the generator reports done/stop.
 */
`timescale 1ns/10ps
`default_nettype none
module motion_start_input_dispatcher
    import dispatch_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire motion_in_t pins,
    input wire logic decelerating,
    output motion_req_t req,
    output home_cfg_t home_cfg,
    output logic origin_reached,
    output logic home_alarm
);
    // ******************************************************
    // Input synchronisation
    // ******************************************************
    localparam int IN_W = $bits(motion_in_t);
    motion_in_t lvl;
    motion_in_t edg;

    input_sync #(.WIDTH(IN_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw(pins),
        .level(lvl),
        .rise(edg)
    );

    // ******************************************************
    // Registers
    // ******************************************************
    logic alarm_en;
    logic home_done_sw;
    logic motor_stopped;
    logic [DATA_W-1:0] direct_map [DIRECT_N];
    logic origin_set;
    logic home_running;

    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;

    function automatic logic mapped(input logic [7:0] a);
        unique case (a)
            CTRL_OFS, STATUS_OFS, MAP_LO_OFS, HOME_MODE_OFS,
            HOME_SPEED_OFS, HOME_START_OFS, HOME_ACCEL_OFS,
            HOME_OFFSET_OFS, PUSH_CUR_OFS, MAP_HI_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // Slave always answers in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
        end
    end

    // Control: alarm enable, completion and stopped flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_en <= 1'b0;
            home_done_sw <= 1'b0;
            motor_stopped <= 1'b1;
        end else if (apb_wr && paddr == CTRL_OFS) begin
            alarm_en <= pwdata[CTRL_ALM_EN];
            home_done_sw <= pwdata[CTRL_DONE];
            motor_stopped <= pwdata[CTRL_STOPPED];
        end else begin
            home_done_sw <= 1'b0;
        end
    end

    // Home settings; out-of-range writes keep the old value, except offset writes, which take pwdata[23:0] unchecked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_cfg.mode <= HOME_MODE_RST;
            home_cfg.positive <= 1'b1;
            home_cfg.slot_sensor <= 1'b0;
            home_cfg.phase_timing_signal <= 1'b0;
            home_cfg.speed <= HOME_SPEED_RST;
            home_cfg.start_speed <= HOME_START_RST;
            home_cfg.accel <= HOME_ACCEL_RST;
            home_cfg.offset <= HOME_OFFSET_RST;
            home_cfg.push_current <= PUSH_CUR_RST;
        end else if (apb_wr) begin
            unique case (paddr)
                HOME_MODE_OFS: begin
                    // Reserved mode code 3 is refused
                    if (pwdata[HM_MODE_LSB +: 2] <= HOME_MODE_MAX)
                        home_cfg.mode <= pwdata[HM_MODE_LSB +: 2];
                    home_cfg.positive <= pwdata[HM_DIR];
                    home_cfg.slot_sensor <= pwdata[HM_SLOT];
                    home_cfg.phase_timing_signal <= pwdata[HM_PHASE];
                end
                HOME_SPEED_OFS:
                    if (pwdata[19:0] >= SPEED_MIN && pwdata[31:20] == '0
                        && pwdata[19:0] <= SPEED_MAX)
                        home_cfg.speed <= pwdata[19:0];
                HOME_START_OFS:
                    if (pwdata[31:20] == '0 && pwdata[19:0] <= SPEED_MAX)
                        home_cfg.start_speed <= pwdata[19:0];
                HOME_ACCEL_OFS:
                    if (pwdata[19:0] >= SPEED_MIN && pwdata[31:20] == '0
                        && pwdata[19:0] <= SPEED_MAX)
                        home_cfg.accel <= pwdata[19:0];
                HOME_OFFSET_OFS: home_cfg.offset <= pwdata[23:0];
                PUSH_CUR_OFS:
                    if (pwdata[31:10] == '0 && pwdata[9:0] <= PUSH_CUR_MAX)
                        home_cfg.push_current <= pwdata[9:0];
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < DIRECT_N; g++) begin : g_map
            localparam int W = g < 4 ? g : g - 4;
            localparam logic [7:0] OFS = g < 4 ? MAP_LO_OFS : MAP_HI_OFS;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    direct_map[g] <= DATA_W'(g);
                else if (apb_wr && paddr == OFS)
                    direct_map[g] <= pwdata[W*8 +: DATA_W];
            end
        end
    endgenerate

    // ******************************************************
    // Request decode
    // ******************************************************
    // Binary number, top line is MSB
    wire [DATA_W-1:0] sel_no = lvl.data_select_lines;
    logic [DATA_W-1:0] seq_no;
    logic [DATA_W-1:0] direct_no;
    logic direct_hit;
    logic pos_start;
    logic both_run;
    logic run_dir;
    logic running;

    always_comb begin
        direct_hit = 1'b0;
        direct_no = '0;
        // Lowest input wins on simultaneous edges
        for (int i = DIRECT_N - 1; i >= 0; i--) begin
            if (edg.direct_select_inputs[i]) begin
                direct_hit = 1'b1;
                direct_no = direct_map[i];
            end
        end
    end

    sequence_counter #(.WIDTH(DATA_W)) u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .load(edg.start || direct_hit),
        .load_value(edg.start ? sel_no : direct_no),
        .step(edg.sequential_start),
        .current(seq_no)
    );

    assign both_run = lvl.forward_run && lvl.reverse_run;
    assign pos_start = edg.start || edg.sequential_start || direct_hit;

    // Continuous direction latched while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= 1'b0;
            run_dir <= 1'b1;
        end else if (both_run || !(lvl.forward_run || lvl.reverse_run)) begin
            running <= 1'b0;
        end else begin
            running <= 1'b1;
            run_dir <= lvl.forward_run;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req <= '0;
        end else begin
            req.valid <= 1'b0;
            if (edg.home) begin
                req <= '{1'b1, REQ_HOME, sel_no, home_cfg.positive};
            end else if (edg.start) begin
                req <= '{1'b1, REQ_POSITION, sel_no, 1'b1};
            end else if (edg.sequential_start) begin
                req <= '{1'b1, REQ_SEQUENTIAL, seq_no, 1'b1};
            end else if (direct_hit) begin
                req <= '{1'b1, REQ_DIRECT, direct_no, 1'b1};
            end else if (both_run && running) begin
                req <= '{1'b1, REQ_DECEL_STOP, sel_no, run_dir};
            end else if (decelerating && !both_run &&
                         (run_dir ? edg.forward_run : edg.reverse_run)) begin
                req <= '{1'b1, REQ_CONTINUOUS, sel_no, run_dir};
            end else if (!both_run &&
                         (edg.forward_run || edg.reverse_run)) begin
                req <= '{1'b1, REQ_CONTINUOUS, sel_no, lvl.forward_run};
            end else if (running && (lvl.forward_run ^ lvl.reverse_run) &&
                         sel_no != req.data_no) begin
                req <= '{1'b1, REQ_CONTINUOUS, sel_no, run_dir};
            end
        end
    end

    // ******************************************************
    // Home status and alarm
    // ******************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_running <= 1'b0;
            origin_set <= 1'b0;
            origin_reached <= 1'b0;
        end else if (edg.home) begin
            home_running <= 1'b1;
            origin_reached <= 1'b0;
        end else if (home_running && home_done_sw && motor_stopped) begin
            home_running <= 1'b0;
            origin_set <= 1'b1;
            origin_reached <= 1'b1;
        end else if (apb_wr && paddr == CTRL_OFS && pwdata[CTRL_ORG_CLR]) begin
            origin_set <= 1'b0;
            origin_reached <= 1'b0;
        end
    end

    // Alarm only when enabled; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            home_alarm <= 1'b0;
        else if (pos_start && !origin_set && alarm_en)
            home_alarm <= 1'b1;
        else if (apb_wr && paddr == CTRL_OFS && pwdata[CTRL_ALM_CLR])
            home_alarm <= 1'b0;
    end

    // ******************************************************
    // Read mux
    // ******************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CTRL_OFS: prdata <= {28'h0, motor_stopped, 2'h0, alarm_en};
                STATUS_OFS: prdata <= {26'h0, sel_no[1:0], running,
                    home_running, origin_reached, home_alarm};
                MAP_LO_OFS: prdata <= {2'h0, direct_map[3], 2'h0,
                    direct_map[2], 2'h0, direct_map[1], 2'h0, direct_map[0]};
                MAP_HI_OFS: prdata <= {18'h0, direct_map[5], 2'h0,
                    direct_map[4]};
                HOME_MODE_OFS: prdata <= {27'h0, home_cfg.phase_timing_signal,
                    home_cfg.slot_sensor, home_cfg.positive, home_cfg.mode};
                HOME_SPEED_OFS: prdata <= {12'h0, home_cfg.speed};
                HOME_START_OFS: prdata <= {12'h0, home_cfg.start_speed};
                HOME_ACCEL_OFS: prdata <= {12'h0, home_cfg.accel};
                HOME_OFFSET_OFS: prdata <= {{8{home_cfg.offset[23]}},
                    home_cfg.offset};
                PUSH_CUR_OFS: prdata <= {22'h0, home_cfg.push_current};
                default: prdata <= '0;
            endcase
        end
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    sequence home_edge_s;
        edg.home;
    endsequence

    home_req_a: assert property (@(posedge pclk) disable iff (!presetn)
        home_edge_s |=> req.valid && req.mode == REQ_HOME)
        else $error("home edge did not issue home request");

    alarm_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !alarm_en && !$past(alarm_en) && !$past(home_alarm)
        |-> !home_alarm)
        else $error("alarm raised while disabled");

    start_no_a: assert property (@(posedge pclk) disable iff (!presetn)
        edg.start && !edg.home |=> req.mode == REQ_POSITION &&
        req.data_no == $past(sel_no))
        else $error("start used wrong data number");

    both_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        both_run && running && !pos_start && !edg.home
        |=> req.mode == REQ_DECEL_STOP)
        else $error("both run inputs did not stop");

    fwd_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        edg.forward_run && !lvl.reverse_run && !pos_start && !edg.home
        |=> req.valid && req.positive)
        else $error("forward run not positive");

    rvs_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        edg.reverse_run && !lvl.forward_run && !pos_start && !edg.home
        |=> req.valid && !req.positive)
        else $error("reverse run not negative");

    origin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        origin_reached |-> origin_set && !home_running)
        else $error("origin reached while homing");

    direct_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        edg.direct_select_inputs[0] && !edg.home && !edg.start &&
        !edg.sequential_start |=> req.mode == REQ_DIRECT &&
        req.data_no == $past(direct_map[0]))
        else $error("direct input used wrong entry");
endmodule // motion_start_input_dispatcher
`default_nettype wire

// File: rtl/dispatch_pkg.sv
/*
 * Constants, types and register map for the motion start dispatcher.
 * Assumes an APB master on pclk and a profile generator downstream.
 */
package dispatch_pkg;

    localparam int DATA_W = 6;
    localparam int DIRECT_N = 6;
    localparam int APB_AW = 8;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MAP_LO_OFS = 8'h08;
    localparam logic [7:0] HOME_MODE_OFS = 8'h0C;
    localparam logic [7:0] HOME_SPEED_OFS = 8'h10;
    localparam logic [7:0] HOME_START_OFS = 8'h14;
    localparam logic [7:0] HOME_ACCEL_OFS = 8'h18;
    localparam logic [7:0] HOME_OFFSET_OFS = 8'h1C;
    localparam logic [7:0] PUSH_CUR_OFS = 8'h20;
    localparam logic [7:0] MAP_HI_OFS = 8'h24;

    // Field positions
    localparam int CTRL_ALM_EN = 0;
    localparam int CTRL_ALM_CLR = 1;
    localparam int CTRL_DONE = 2;
    localparam int CTRL_STOPPED = 3;
    localparam int CTRL_ORG_CLR = 4;
    localparam int HM_MODE_LSB = 0;
    localparam int HM_DIR = 2;
    localparam int HM_SLOT = 3;
    localparam int HM_PHASE = 4;

    // Reset values and write limits
    localparam logic [1:0] HOME_MODE_RST = 2'h1;
    localparam logic [19:0] HOME_SPEED_RST = 20'h003E8;
    localparam logic [19:0] HOME_START_RST = 20'h001F4;
    localparam logic [19:0] HOME_ACCEL_RST = 20'h003E8;
    localparam logic [23:0] HOME_OFFSET_RST = 24'h000000;
    localparam logic [9:0] PUSH_CUR_RST = 10'h3E8;
    localparam logic [9:0] PUSH_CUR_MAX = 10'h3E8;
    localparam logic [1:0] HOME_MODE_MAX = 2'h2;
    localparam logic [19:0] SPEED_MAX = 20'hF4240;
    localparam logic [19:0] SPEED_MIN = 20'h00001;

    typedef enum logic [2:0] {
        REQ_NONE,
        REQ_POSITION,
        REQ_SEQUENTIAL,
        REQ_DIRECT,
        REQ_HOME,
        REQ_CONTINUOUS,
        REQ_DECEL_STOP
    } req_mode_t;

    typedef struct packed {
        logic start;
        logic [DATA_W-1:0] data_select_lines;
        logic sequential_start;
        logic [DIRECT_N-1:0] direct_select_inputs;
        logic home;
        logic forward_run;
        logic reverse_run;
    } motion_in_t;

    typedef struct packed {
        logic valid;
        req_mode_t mode;
        logic [DATA_W-1:0] data_no;
        logic positive;
    } motion_req_t;

    typedef struct packed {
        logic [1:0] mode;
        logic positive;
        logic slot_sensor;
        logic phase_timing_signal;
        logic [19:0] speed;
        logic [19:0] start_speed;
        logic [19:0] accel;
        logic [23:0] offset;
        logic [9:0] push_current;
    } home_cfg_t;

endpackage

// File: rtl/input_sync.sv
/*
 * Two-stage synchroniser with rising-edge pulse per bit.
 * Assumes asynchronous inputs from pins or remote I/O.
 */
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= raw;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level = stable;
    assign rise = stable & ~prev;
endmodule // input_sync
`default_nettype wire

// File: rtl/sequence_counter.sv
/*
 * Sequential data number counter for sequential positioning.
 * Assumes load and step pulses from the dispatcher on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module sequence_counter #(
    parameter int WIDTH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic step,
    output logic [WIDTH-1:0] current
);
    logic started;
    logic [WIDTH-1:0] last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started <= 1'b0;
            last <= '0;
        end else if (load) begin
            started <= 1'b1;
            last <= load_value;
        end else if (step) begin
            started <= 1'b1;
            last <= current;
        end
    end

    // Before any load, the first sequential start uses entry zero
    assign current = started ? last + 1'b1 : '0;
endmodule // sequence_counter
`default_nettype wire

// File: test/host_model.sv
/*
 * Host side of the motion inputs: drives start, select and run levels.
 * Assumes one clock; the bench calls set_pins between transfers.
 */
`timescale 1ns/10ps
`default_nettype none
module host_model
    import dispatch_pkg::*;
(
    input wire logic pclk,
    output var motion_in_t pins
);
    initial pins = '0;

    // Select with trigger
    // Held at least until the next call, well over two cycles
    task set_pins(input motion_in_t v);
        @(posedge pclk);
        pins <= v;
    endtask
endmodule // host_model
`default_nettype wire

// File: test/testbench.sv
/*
 * Self-checking bench for the motion start dispatcher.
 * Assumes host_model drives the pins and APB has zero wait states.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dispatch_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic decelerating = 1'b0;
    motion_in_t pins;
    motion_in_t cur;
    motion_req_t req;
    home_cfg_t home_cfg;
    logic origin_reached;
    logic home_alarm;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] ofs [8] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
        8'h08, 8'h24};
    logic [31:0] rst [8] = '{32'h5, 32'h3E8, 32'h1F4, 32'h3E8, 32'h0,
        32'h3E8, 32'h03020100, 32'h504};

    always #5 pclk = ~pclk;

    host_model host (.pclk(pclk), .pins(pins));

    motion_start_input_dispatcher dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .decelerating(decelerating),
        .req(req), .home_cfg(home_cfg), .origin_reached(origin_reached),
        .home_alarm(home_alarm));

    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Generous ceiling: the whole run needs well under 1000 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles > 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task act(input motion_in_t v, input req_mode_t m, input logic [5:0] d);
        host.set_pins(v);
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (req.valid === 1'b1)
                break;
        end
        chk(req.valid, 1'b1);
        chk(req.mode, m);
        chk(req.data_no, d);
        host.set_pins(cur);
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, rst[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // Mode 3 refused, direction bit kept
        apb(1'b1, 8'h0C, 32'h7);
        apb(1'b1, 8'h20, 32'h3E9);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h3E8);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h3E8);
        apb(1'b1, 8'h0C, 32'h1A);
        apb(1'b1, 8'h1C, 32'h800000);
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'hFF800000);
        chk({home_cfg.mode, home_cfg.positive}, 3'h4);
        chk(home_cfg.slot_sensor, 1'b1);
        chk(home_cfg.phase_timing_signal, 1'b1);
        chk(home_cfg.start_speed, 20'h1F4);
        chk(home_cfg.accel, 20'h3E8);
        $display("settings test done");
        cur = '0;
        cur.data_select_lines = 6'h2A;
        host.set_pins(cur);
        repeat (4) @(posedge pclk);
        // Masks: start 16, seq 9, direct 8..3, home 2, reverse 0
        act(cur | 17'h10000, REQ_POSITION, 6'h2A);
        chk(home_alarm, 1'b0);
        act(cur | 17'h00200, REQ_SEQUENTIAL, 6'h2B);
        act(cur | 17'h00200, REQ_SEQUENTIAL, 6'h2C);
        apb(1'b1, 8'h08, 32'h0302013F);
        act(cur | 17'h00008, REQ_DIRECT, 6'h3F);
        act(cur | 17'h00100, REQ_DIRECT, 6'h05);
        apb(1'b1, 8'h00, 32'h1);
        act(cur | 17'h10000, REQ_POSITION, 6'h2A);
        chk(home_alarm, 1'b1);
        apb(1'b1, 8'h00, 32'h3);
        @(posedge pclk);
        chk(home_alarm, 1'b0);
        $display("positioning test done");
        act(cur | 17'h00004, REQ_HOME, 6'h2A);
        chk(origin_reached, 1'b0);
        apb(1'b1, 8'h00, 32'hD);
        repeat (2) @(posedge pclk);
        chk(origin_reached, 1'b1);
        $display("home test done");
        cur.forward_run = 1'b1;
        act(cur, REQ_CONTINUOUS, 6'h2A);
        chk(req.positive, 1'b1);
        cur.data_select_lines = 6'h11;
        act(cur, REQ_CONTINUOUS, 6'h11);
        act(cur | 17'h00001, REQ_DECEL_STOP, 6'h11);
        cur = '0;
        host.set_pins(cur);
        repeat (6) @(posedge pclk);
        cur.reverse_run = 1'b1;
        act(cur, REQ_CONTINUOUS, 6'h00);
        chk(req.positive, 1'b0);
        $display("continuous test done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
